//--- verification/tbfo_assertions.sv
// port checks for the type b framing block
`timescale 1ns/1ps
`include "tbfo_defs.svh"
module tbfo_assertions (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [7:0]  awaddr,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0]  wstrb,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic [7:0]  araddr,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic        tx_start,
   input wire logic        tx_valid,
   input wire logic        tx_ready,
   input wire logic        tx_out,
   input wire logic        tx_busy,
   input wire logic        rx_byte_valid,
   input wire logic [7:0]  rx_byte,
   input wire logic        fifo_wr,
   input wire logic [7:0]  fifo_data
);
   logic [7:0] wa_r, wa_nxt, ra_r, ra_nxt, wd_r, wd_nxt, ctrl_r, ctrl_nxt;
   logic       ws_r, ws_nxt;
   function automatic logic mapped(input logic [7:0] a);
      return a == `TBFO_ADDR_CTRL || a == `TBFO_ADDR_STS || a == `TBFO_ADDR_MASK;
   endfunction
   // shadow of the control register, rebuilt from completed writes
   always_comb
   begin
      wa_nxt = (awvalid && awready) ? awaddr : wa_r;
      wd_nxt = (wvalid && wready) ? wdata[7:0] : wd_r;
      ws_nxt = (wvalid && wready) ? wstrb[0] : ws_r;
      ra_nxt = (arvalid && arready) ? araddr : ra_r;
      ctrl_nxt = ctrl_r;
      if (!aresetn)
         ctrl_nxt = `TBFO_CTRL_RST;
      else if (bvalid && bready && wa_r == `TBFO_ADDR_CTRL && ws_r)
         ctrl_nxt = wd_r & `TBFO_CTRL_WMASK;
   end
   always_ff @(posedge aclk)
   begin
      {wa_r, wd_r, ws_r, ra_r, ctrl_r} <= {wa_nxt, wd_nxt, ws_nxt, ra_nxt, ctrl_nxt};
   end
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_ctrl_read: assert property (
      rvalid && ra_r == `TBFO_ADDR_CTRL |-> rdata == {24'h0, ctrl_r})
      else $error("control read value wrong");
   a_unmapped_read: assert property (
      rvalid && !mapped(ra_r) |-> rresp == `TBFO_RESP_SLVERR && rdata == 32'h0)
      else $error("unmapped read not refused");
   a_unmapped_write: assert property (
      bvalid && !mapped(wa_r) |-> bresp == `TBFO_RESP_SLVERR)
      else $error("unmapped write not refused");
   a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
   a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped early");
   a_fifo_source: assert property (
      fifo_wr |-> $past(rx_byte_valid) && fifo_data == $past(rx_byte))
      else $error("fifo write without received byte");
   a_tx_first_level: assert property (
      tx_start && !tx_busy |=> tx_busy && tx_out == ctrl_r[`TBFO_B_TX_NO_SOF])
      else $error("frame start level wrong");
   a_tx_idle_high: assert property (!tx_busy && !$past(tx_busy) |-> tx_out)
      else $error("line not high while idle");
   // a taken byte must start its character at once with a low start bit
   a_tx_ready_busy: assert property (
      tx_ready && tx_valid |=> tx_busy && !tx_ready && !tx_out)
      else $error("byte taken without start bit");
endmodule
bind tbfo_top tbfo_assertions chk (.*);

//--- verification/tbfo_peer.sv
// far-side model: carrier ticks and decoded receive events
`timescale 1ns/1ps
module tbfo_peer #(
   parameter int DIV = 5
) (
   input  wire logic  aclk,
   output logic       fc_tick,
   output logic       rx_sof,
   output logic       rx_eof,
   output logic       rx_end,
   output logic       rx_byte_valid,
   output logic [7:0] rx_byte
);
   int div_r = 0;
   initial
   begin
      {fc_tick, rx_sof, rx_eof, rx_end, rx_byte_valid} = 5'b00000;
      rx_byte = 8'h00;
   end
   // carrier runs free while the field is on
   always @(posedge aclk)
   begin
      div_r <= (div_r == DIV - 1) ? 0 : div_r + 1;
      fc_tick <= (div_r == DIV - 1);
   end
   task automatic stream(input logic sof, input logic eof, input logic [7:0] b [3]);
      @(posedge aclk);
      rx_sof <= sof;
      foreach (b[i])
      begin
         @(posedge aclk);
         rx_sof <= 1'b0;
         rx_byte_valid <= 1'b1;
         rx_byte <= b[i];
      end
      @(posedge aclk);
      rx_byte_valid <= 1'b0;
      // idle decoder data carries nothing, so show a changed pattern
      rx_byte <= ~rx_byte;
      rx_eof <= eof;
      @(posedge aclk);
      rx_eof <= 1'b0;
      rx_end <= 1'b1;
      @(posedge aclk);
      rx_end <= 1'b0;
   endtask
endmodule

//--- verification/type_b_frame_options_tb.sv
// self-checking bench for the type b framing block
`timescale 1ns/1ps
`include "tbfo_defs.svh"
module type_b_frame_options_tb;
   localparam int ETU = 6;
   localparam int LO_MIN = 10, LO_MAX = 11, HI_MIN = 2, HI_MAX = 3;
   logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, tx_data = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0]  wstrb = 4'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        delimiter_timing_adjust = 1'b0, tx_start = 1'b0, tx_valid = 1'b0;
   logic        tx_last = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, tx_ready, tx_out, tx_busy;
   logic        fifo_wr, irq, fc_tick, rx_sof, rx_eof, rx_end, rx_byte_valid;
   logic [1:0]  bresp, rresp, r;
   logic [31:0] rdata, d;
   logic [7:0]  fifo_data, rx_byte;
   logic [7:0]  got_q[$], exp_q[$];
   logic        act_l[$], exp_l[$];
   int          act_n[$], exp_n[$];
   int          mismatches = 0, n_compared = 0;
   tbfo_top #(.ETU_FC(ETU), .SOF_LO_MIN(LO_MIN), .SOF_LO_MAX(LO_MAX),
      .SOF_HI_MIN(HI_MIN), .SOF_HI_MAX(HI_MAX)) dut (.*);
   tbfo_peer peer (.*);
   initial
      forever #10 aclk = ~aclk;
   always @(posedge aclk)
      if (fifo_wr === 1'b1)
         got_q.push_back(fifo_data);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("mismatches %0d compared %0d", mismatches, n_compared);
      if (mismatches == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hf;
      {awvalid, wvalid, bready} <= 3'b111;
      do
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'b11;
      do
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   // expected line segments in carrier ticks, equal levels merged
   task automatic seg(input logic lv, input int n);
      if (n == 0)
         return;
      if (exp_l.size() > 0 && exp_l[$] == lv)
         exp_n[$] += n;
      else
      begin
         exp_l.push_back(lv);
         exp_n.push_back(n);
      end
   endtask
   task automatic tx_frame(input logic [7:0] b0, input logic [7:0] b1);
      logic lv;
      int   cnt;
      act_l.delete();
      act_n.delete();
      cnt = 0;
      @(posedge aclk);
      {tx_start, tx_valid, tx_last} <= 3'b110;
      tx_data <= b0;
      @(posedge aclk);
      tx_start <= 1'b0;
      @(posedge aclk);
      lv = tx_out;
      while (tx_busy === 1'b1)
      begin
         if (tx_out !== lv)
         begin
            act_l.push_back(lv);
            act_n.push_back(cnt);
            lv = tx_out;
            cnt = 0;
         end
         if (fc_tick === 1'b1)
            cnt++;
         if (tx_valid && tx_ready === 1'b1)
         begin
            tx_data <= tx_last ? ~b1 : b1;
            tx_last <= 1'b1;
            tx_valid <= !tx_last;
         end
         @(posedge aclk);
      end
      act_l.push_back(lv);
      act_n.push_back(cnt);
   endtask
   initial
   begin
      #800_000;
      mismatches++;
      summarize();
   end
   initial
   begin
      logic [7:0] b [3];
      logic       sq, eq, sp, ep, drop, perr, wd, ss, es;
      int         lo, hi;
      void'($urandom(32800));
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`TBFO_ADDR_CTRL, d, r);
      check(d, 32'h0000_0000);
      wr(`TBFO_ADDR_CTRL, 32'h0000_00ff, r);
      rd(`TBFO_ADDR_CTRL, d, r);
      check(d, 32'h0000_00df);
      wr(8'hfc, 32'h0000_0001, r);
      check(r, `TBFO_RESP_SLVERR);
      rd(8'hfc, d, r);
      check(r, `TBFO_RESP_SLVERR);
      // only protocol errors interrupt; frame-done stays masked
      wr(`TBFO_ADDR_MASK, 32'h0000_0002, r);
      for (int k = 0; k < 16; k++)
      begin
         {sq, eq, sp, ep} = 4'(k);
         drop = sq && !sp;
         perr = !drop && eq && !ep;
         wr(`TBFO_ADDR_CTRL, {24'h0, sq, eq, 6'h00}, r);
         foreach (b[i])
         begin
            b[i] = 8'($urandom);
            if (!drop)
               exp_q.push_back(b[i]);
         end
         peer.stream(sp, ep, b);
         repeat (3) @(posedge aclk);
         check(irq, perr);
         rd(`TBFO_ADDR_STS, d, r);
         check(d[3:0], {1'b0, drop, perr, !drop});
         repeat (3) @(posedge aclk);
         check(irq, 1'b0);
         check(got_q.size(), exp_q.size());
         while (got_q.size() > 0 && exp_q.size() > 0)
            check(got_q.pop_front(), exp_q.pop_front());
      end
      for (int f = 0; f < 4; f++)
      begin
         wd = (f == 1 || f == 2);
         ss = (f == 1);
         es = (f == 2);
         delimiter_timing_adjust <= (f == 2);
         wr(`TBFO_ADDR_CTRL, {24'h0, 3'b000, wd, ss, es, 2'(f)}, r);
         lo = !wd ? LO_MIN * ETU : (f == 2) ? 11 * ETU - 8 : LO_MAX * ETU;
         hi = !wd ? HI_MIN * ETU : (f == 2) ? 2 * ETU + 8 : HI_MAX * ETU;
         b[0] = 8'($urandom);
         b[1] = 8'($urandom);
         exp_l.delete();
         exp_n.delete();
         // with no start delimiter the line sits high for the byte fetch
         if (ss)
            seg(1'b1, 1);
         else
         begin
            seg(1'b0, lo);
            seg(1'b1, hi);
         end
         for (int j = 0; j < 2; j++)
         begin
            seg(1'b0, ETU);
            for (int i = 0; i < 8; i++)
               seg(b[j][i], ETU);
            seg(1'b1, ETU);
            if (j == 0)
               seg(1'b1, f * ETU);
         end
         if (!es)
            seg(1'b0, lo);
         if (ss)
            exp_n[0] = 0;
         tx_frame(b[0], b[1]);
         rd(`TBFO_ADDR_STS, d, r);
         check(d[3:0], 4'h8);
         check(act_l.size(), exp_l.size());
         for (int k = 0; k < exp_l.size() && k < act_l.size(); k++)
         begin
            check(act_l[k], exp_l[k]);
            check(act_n[k] == exp_n[k] || (exp_l[k] && act_n[k] == exp_n[k] + 1), 1'b1);
         end
      end
      summarize();
   end
endmodule

//--- verilog/tbfo_defs.svh
// register map, field positions, reset values and bus codes of the framing block
`ifndef TBFO_DEFS_SVH
`define TBFO_DEFS_SVH
`define TBFO_IDX_CTRL     6'h1e
`define TBFO_IDX_STS      6'h20
`define TBFO_IDX_MASK     6'h21
`define TBFO_ADDR_CTRL    {`TBFO_IDX_CTRL, 2'b00}
`define TBFO_ADDR_STS     {`TBFO_IDX_STS, 2'b00}
`define TBFO_ADDR_MASK    {`TBFO_IDX_MASK, 2'b00}
`define TBFO_CTRL_RST     8'h00
`define TBFO_CTRL_WMASK   8'hdf
`define TBFO_B_RX_SOF_REQ 7
`define TBFO_B_RX_EOF_REQ 6
`define TBFO_B_WIDTH_MAX  4
`define TBFO_B_TX_NO_SOF  3
`define TBFO_B_TX_NO_EOF  2
`define TBFO_STS_RST      4'h0
`define TBFO_MASK_RST     4'h0
`define TBFO_S_RX_DONE    0
`define TBFO_S_PROTO_ERR  1
`define TBFO_S_RX_DROP    2
`define TBFO_S_TX_DONE    3
`define TBFO_ADJ_FC       12'h008
`define TBFO_ADJ_LO_ETU   11
`define TBFO_ADJ_HI_ETU   2
`define TBFO_CHAR_BITS    4'h9
`define TBFO_RESP_OKAY    2'b00
`define TBFO_RESP_SLVERR  2'b10
`endif

//--- verilog/tbfo_pkg.sv
// state types of the framing block
package tbfo_pkg;
   typedef enum logic [2:0] {
      TX_IDLE   = 3'b000,
      TX_SOF_LO = 3'b001,
      TX_SOF_HI = 3'b010,
      TX_LOAD   = 3'b011,
      TX_DATA   = 3'b100,
      TX_EGT    = 3'b101,
      TX_EOF_LO = 3'b110
   } tbfo_tx_st_t;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_DATA = 2'b01,
      RX_DROP = 2'b10
   } tbfo_rx_st_t;
endpackage

//--- verilog/tbfo_top.sv
// type b framing options: delimiter handling on receive and transmit, axi4-lite registers
//
// How it works
// - sof required: stream without sof is dropped
// - sof optional: any sof stripped, never stored
// - eof required: missing eof flags protocol error
// - eof optional: any eof stripped, never stored
// - width one, adjust zero: maximum delimiter lengths
// - width zero, adjust zero: minimum delimiter lengths
// - both one: 11etu-8, 2etu+8, 11etu-8 cycles
// - tx sof suppress bit omits sof
// - tx eof suppress bit omits eof
// - egt field adds 0 to 3 etu
// - bit 5 reserved, reads zero
// - control register resets to 00h
`timescale 1ns/1ps
`include "tbfo_defs.svh"
module tbfo_top #(
   parameter int ETU_FC     = 128,
   parameter int SOF_LO_MIN = 10,
   parameter int SOF_LO_MAX = 11,
   parameter int SOF_HI_MIN = 2,
   parameter int SOF_HI_MAX = 3
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        delimiter_timing_adjust,
   input  wire logic        fc_tick,
   input  wire logic        tx_start,
   input  wire logic [7:0]  tx_data,
   input  wire logic        tx_valid,
   input  wire logic        tx_last,
   output logic             tx_ready,
   output logic             tx_out,
   output logic             tx_busy,
   input  wire logic        rx_sof,
   input  wire logic        rx_eof,
   input  wire logic        rx_end,
   input  wire logic        rx_byte_valid,
   input  wire logic [7:0]  rx_byte,
   output logic             fifo_wr,
   output logic [7:0]       fifo_data,
   output logic             irq
);
   localparam logic [11:0] ETU    = 12'(ETU_FC);
   localparam logic [11:0] MIN_LO = 12'(ETU_FC * SOF_LO_MIN);
   localparam logic [11:0] MAX_LO = 12'(ETU_FC * SOF_LO_MAX);
   localparam logic [11:0] MIN_HI = 12'(ETU_FC * SOF_HI_MIN);
   localparam logic [11:0] MAX_HI = 12'(ETU_FC * SOF_HI_MAX);
   localparam logic [11:0] ADJ_LO = 12'(ETU_FC * `TBFO_ADJ_LO_ETU) - `TBFO_ADJ_FC;
   localparam logic [11:0] ADJ_HI = 12'(ETU_FC * `TBFO_ADJ_HI_ETU) + `TBFO_ADJ_FC;

   logic [7:0]  ctrl_r, ctrl_nxt;
   logic [3:0]  mask_r, mask_nxt;
   logic [3:0]  sts_r, sts_nxt;
   logic        sts_clr;
   logic        aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
   logic [7:0]  aw_addr_r, aw_addr_nxt;
   logic [31:0] w_data_r, w_data_nxt;
   logic [3:0]  w_strb_r, w_strb_nxt;
   logic        awready_nxt, wready_nxt, arready_nxt, bvalid_nxt, rvalid_nxt, irq_nxt;
   logic [1:0]  bresp_nxt, rresp_nxt;
   logic [31:0] rdata_nxt;
   logic [7:0]  wa;
   logic [31:0] wd;
   logic [3:0]  ws;

   tbfo_pkg::tbfo_tx_st_t tx_st_r, tx_st_nxt;
   logic [11:0] cyc_r, cyc_nxt, len, lo_len, hi_len;
   logic [3:0]  bit_r, bit_nxt;
   logic [9:0]  sh_r, sh_nxt;
   logic        last_r, last_nxt, tick_end, tx_done_ev;
   logic        tx_ready_nxt, tx_out_nxt, tx_busy_nxt;

   tbfo_pkg::tbfo_rx_st_t rx_st_r, rx_st_nxt;
   logic        eof_seen_r, eof_seen_nxt, fifo_wr_nxt;
   logic [7:0]  fifo_data_nxt;
   logic        rx_done_ev, err_ev, drop_ev;

   // register bus: write address and data may arrive in either order
   always_comb
   begin
      ctrl_nxt    = ctrl_r;
      mask_nxt    = mask_r;
      aw_have_nxt = aw_have_r;
      w_have_nxt  = w_have_r;
      aw_addr_nxt = aw_addr_r;
      w_data_nxt  = w_data_r;
      w_strb_nxt  = w_strb_r;
      bvalid_nxt  = bvalid;
      bresp_nxt   = bresp;
      rvalid_nxt  = rvalid;
      rresp_nxt   = rresp;
      rdata_nxt   = rdata;
      sts_clr     = 1'b0;
      wa          = aw_addr_r;
      wd          = w_data_r;
      ws          = w_strb_r;
      if (awvalid && awready)
      begin
         aw_have_nxt = 1'b1;
         aw_addr_nxt = awaddr;
         wa          = awaddr;
      end
      if (wvalid && wready)
      begin
         w_have_nxt = 1'b1;
         w_data_nxt = wdata;
         w_strb_nxt = wstrb;
         wd         = wdata;
         ws         = wstrb;
      end
      if (bvalid && bready)
         bvalid_nxt = 1'b0;
      if (aw_have_nxt && w_have_nxt && !bvalid)
      begin
         aw_have_nxt = 1'b0;
         w_have_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = `TBFO_RESP_OKAY;
         if (wa == `TBFO_ADDR_CTRL)
         begin
            if (ws[0])
               ctrl_nxt = wd[7:0] & `TBFO_CTRL_WMASK;
         end
         else if (wa == `TBFO_ADDR_MASK)
         begin
            if (ws[0])
               mask_nxt = wd[3:0];
         end
         else if (wa != `TBFO_ADDR_STS)
            bresp_nxt = `TBFO_RESP_SLVERR;
      end
      if (rvalid && rready)
         rvalid_nxt = 1'b0;
      if (arvalid && arready)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = `TBFO_RESP_OKAY;
         rdata_nxt  = 32'h0000_0000;
         if (araddr == `TBFO_ADDR_CTRL)
            rdata_nxt[7:0] = ctrl_r & `TBFO_CTRL_WMASK;
         else if (araddr == `TBFO_ADDR_STS)
         begin
            rdata_nxt[3:0] = sts_r;
            sts_clr        = 1'b1;
         end
         else if (araddr == `TBFO_ADDR_MASK)
            rdata_nxt[3:0] = mask_r;
         else
            rresp_nxt = `TBFO_RESP_SLVERR;
      end
      awready_nxt = !aw_have_nxt;
      wready_nxt  = !w_have_nxt;
      arready_nxt = !rvalid_nxt;
      // a read clears only what it returned; events of the same cycle survive
      sts_nxt = (sts_r & ~(sts_clr ? sts_r : 4'h0));
      sts_nxt[`TBFO_S_RX_DONE]   = sts_nxt[`TBFO_S_RX_DONE] | rx_done_ev;
      sts_nxt[`TBFO_S_PROTO_ERR] = sts_nxt[`TBFO_S_PROTO_ERR] | err_ev;
      sts_nxt[`TBFO_S_RX_DROP]   = sts_nxt[`TBFO_S_RX_DROP] | drop_ev;
      sts_nxt[`TBFO_S_TX_DONE]   = sts_nxt[`TBFO_S_TX_DONE] | tx_done_ev;
      irq_nxt = |(sts_nxt & mask_nxt);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_r    <= `TBFO_CTRL_RST;
         mask_r    <= `TBFO_MASK_RST;
         sts_r     <= `TBFO_STS_RST;
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
         awready   <= 1'b1;
         wready    <= 1'b1;
         arready   <= 1'b1;
         bvalid    <= 1'b0;
         bresp     <= `TBFO_RESP_OKAY;
         rvalid    <= 1'b0;
         rresp     <= `TBFO_RESP_OKAY;
         rdata     <= 32'h0000_0000;
         irq       <= 1'b0;
      end
      else if (ce)
      begin
         ctrl_r    <= ctrl_nxt;
         mask_r    <= mask_nxt;
         sts_r     <= sts_nxt;
         aw_have_r <= aw_have_nxt;
         w_have_r  <= w_have_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_data_r  <= w_data_nxt;
         w_strb_r  <= w_strb_nxt;
         awready   <= awready_nxt;
         wready    <= wready_nxt;
         arready   <= arready_nxt;
         bvalid    <= bvalid_nxt;
         bresp     <= bresp_nxt;
         rvalid    <= rvalid_nxt;
         rresp     <= rresp_nxt;
         rdata     <= rdata_nxt;
         irq       <= irq_nxt;
      end
   end

   // transmit sequencer, timed in carrier cycles counted on fc_tick
   always_comb
   begin
      // adjust without width is outside the standard; it falls back to minimum
      if (ctrl_r[`TBFO_B_WIDTH_MAX] && delimiter_timing_adjust)
      begin
         lo_len = ADJ_LO;
         hi_len = ADJ_HI;
      end
      else if (ctrl_r[`TBFO_B_WIDTH_MAX])
      begin
         lo_len = MAX_LO;
         hi_len = MAX_HI;
      end
      else
      begin
         lo_len = MIN_LO;
         hi_len = MIN_HI;
      end
      case (tx_st_r)
         tbfo_pkg::TX_SOF_LO : len = lo_len;
         tbfo_pkg::TX_SOF_HI : len = hi_len;
         tbfo_pkg::TX_EOF_LO : len = lo_len;
         default             : len = ETU;
      endcase
      tx_st_nxt  = tx_st_r;
      cyc_nxt    = cyc_r;
      bit_nxt    = bit_r;
      sh_nxt     = sh_r;
      last_nxt   = last_r;
      tx_done_ev = 1'b0;
      tick_end   = fc_tick && (cyc_r == len - 12'h001);
      if (fc_tick && tx_st_r != tbfo_pkg::TX_IDLE && tx_st_r != tbfo_pkg::TX_LOAD)
         cyc_nxt = tick_end ? 12'h000 : cyc_r + 12'h001;
      case (tx_st_r)
         tbfo_pkg::TX_IDLE :
            if (tx_start)
            begin
               cyc_nxt = 12'h000;
               if (ctrl_r[`TBFO_B_TX_NO_SOF])
                  tx_st_nxt = tbfo_pkg::TX_LOAD;
               else
                  tx_st_nxt = tbfo_pkg::TX_SOF_LO;
            end
         tbfo_pkg::TX_SOF_LO :
            if (tick_end)
               tx_st_nxt = tbfo_pkg::TX_SOF_HI;
         tbfo_pkg::TX_SOF_HI :
            if (tick_end)
               tx_st_nxt = tbfo_pkg::TX_LOAD;
         tbfo_pkg::TX_LOAD :
            if (tx_ready && tx_valid)
            begin
               sh_nxt    = {1'b1, tx_data, 1'b0};
               last_nxt  = tx_last;
               bit_nxt   = 4'h0;
               cyc_nxt   = 12'h000;
               tx_st_nxt = tbfo_pkg::TX_DATA;
            end
         tbfo_pkg::TX_DATA :
            if (tick_end)
            begin
               sh_nxt  = {1'b1, sh_r[9:1]};
               bit_nxt = bit_r + 4'h1;
               if (bit_r == `TBFO_CHAR_BITS)
               begin
                  bit_nxt = 4'h0;
                  if (last_r && ctrl_r[`TBFO_B_TX_NO_EOF])
                  begin
                     tx_st_nxt  = tbfo_pkg::TX_IDLE;
                     tx_done_ev = 1'b1;
                  end
                  else if (last_r)
                     tx_st_nxt = tbfo_pkg::TX_EOF_LO;
                  else if (ctrl_r[1:0] != 2'b00)
                     tx_st_nxt = tbfo_pkg::TX_EGT;
                  else
                     tx_st_nxt = tbfo_pkg::TX_LOAD;
               end
            end
         tbfo_pkg::TX_EGT :
            if (tick_end)
            begin
               bit_nxt = bit_r + 4'h1;
               if (bit_r == {2'b00, ctrl_r[1:0]} - 4'h1)
               begin
                  bit_nxt   = 4'h0;
                  tx_st_nxt = tbfo_pkg::TX_LOAD;
               end
            end
         tbfo_pkg::TX_EOF_LO :
            if (tick_end)
            begin
               tx_st_nxt  = tbfo_pkg::TX_IDLE;
               tx_done_ev = 1'b1;
            end
         default :
            tx_st_nxt = tbfo_pkg::TX_IDLE;
      endcase
      case (tx_st_nxt)
         tbfo_pkg::TX_SOF_LO : tx_out_nxt = 1'b0;
         tbfo_pkg::TX_EOF_LO : tx_out_nxt = 1'b0;
         tbfo_pkg::TX_DATA   : tx_out_nxt = sh_nxt[0];
         default             : tx_out_nxt = 1'b1;
      endcase
      tx_ready_nxt = (tx_st_nxt == tbfo_pkg::TX_LOAD);
      tx_busy_nxt  = (tx_st_nxt != tbfo_pkg::TX_IDLE);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tx_st_r  <= tbfo_pkg::TX_IDLE;
         cyc_r    <= 12'h000;
         bit_r    <= 4'h0;
         sh_r     <= 10'h3ff;
         last_r   <= 1'b0;
         tx_ready <= 1'b0;
         tx_out   <= 1'b1;
         tx_busy  <= 1'b0;
      end
      else if (ce)
      begin
         tx_st_r  <= tx_st_nxt;
         cyc_r    <= cyc_nxt;
         bit_r    <= bit_nxt;
         sh_r     <= sh_nxt;
         last_r   <= last_nxt;
         tx_ready <= tx_ready_nxt;
         tx_out   <= tx_out_nxt;
         tx_busy  <= tx_busy_nxt;
      end
   end

   // receive filter: delimiters never reach the fifo
   always_comb
   begin
      rx_st_nxt     = rx_st_r;
      eof_seen_nxt  = eof_seen_r;
      fifo_wr_nxt   = 1'b0;
      fifo_data_nxt = fifo_data;
      rx_done_ev    = 1'b0;
      err_ev        = 1'b0;
      drop_ev       = 1'b0;
      case (rx_st_r)
         tbfo_pkg::RX_IDLE :
         begin
            eof_seen_nxt = 1'b0;
            if (rx_sof)
               rx_st_nxt = tbfo_pkg::RX_DATA;
            else if (rx_byte_valid && ctrl_r[`TBFO_B_RX_SOF_REQ])
            begin
               rx_st_nxt = tbfo_pkg::RX_DROP;
               drop_ev   = 1'b1;
            end
            else if (rx_byte_valid)
            begin
               fifo_wr_nxt   = 1'b1;
               fifo_data_nxt = rx_byte;
               rx_st_nxt     = tbfo_pkg::RX_DATA;
            end
         end
         tbfo_pkg::RX_DATA :
         begin
            // bytes after the eof are not data of this frame
            if (rx_byte_valid && !eof_seen_r)
            begin
               fifo_wr_nxt   = 1'b1;
               fifo_data_nxt = rx_byte;
            end
            if (rx_eof)
               eof_seen_nxt = 1'b1;
            if (rx_end)
            begin
               rx_st_nxt  = tbfo_pkg::RX_IDLE;
               rx_done_ev = 1'b1;
               if (ctrl_r[`TBFO_B_RX_EOF_REQ] && !eof_seen_r && !rx_eof)
                  err_ev = 1'b1;
            end
         end
         tbfo_pkg::RX_DROP :
            if (rx_end)
               rx_st_nxt = tbfo_pkg::RX_IDLE;
         default :
            rx_st_nxt = tbfo_pkg::RX_IDLE;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rx_st_r    <= tbfo_pkg::RX_IDLE;
         eof_seen_r <= 1'b0;
         fifo_wr    <= 1'b0;
         fifo_data  <= 8'h00;
      end
      else if (ce)
      begin
         rx_st_r    <= rx_st_nxt;
         eof_seen_r <= eof_seen_nxt;
         fifo_wr    <= fifo_wr_nxt;
         fifo_data  <= fifo_data_nxt;
      end
   end
endmodule
